// *** verilog/rtcs_defines.svh ***
// Purpose: Constants for the reset time-out sequencer and reset-cause status block
// Assumes: 200 MHz reference clock; offsets are byte addresses on the register port
// Notes: Timing counts follow from the nominal times and the clock rate
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH

// Clock rate in MHz
`define RTCS_CLK_MHZ 200
// Power-up timer, nominal time and cycles
`define RTCS_PWRUP_TIME_US 65500
`define RTCS_PWRUP_CYCLES (`RTCS_PWRUP_TIME_US * `RTCS_CLK_MHZ)
// PLL lock delay, nominal time and cycles
`define RTCS_PLL_TIME_US 2000
`define RTCS_PLL_CYCLES (`RTCS_PLL_TIME_US * `RTCS_CLK_MHZ)
// Oscillator start-up count in oscillator periods
`define RTCS_START_PERIODS 1024
// Program counter step on resume from a wake-up
`define RTCS_PC_STEP 2

// Register byte addresses
`define RTCS_ADDR_CONFIG 8'h00
`define RTCS_ADDR_STATUS 8'h04
`define RTCS_ADDR_PC 8'h08
`define RTCS_ADDR_SEQ 8'h0C
`define RTCS_ADDR_SCRATCH 8'h10

// Configuration register fields
`define RTCS_CFG_OSC_LSB 0
`define RTCS_CFG_OSC_MSB 2
`define RTCS_CFG_PWRUP_DIS 3
`define RTCS_CFG_BOC_LSB 4
`define RTCS_CFG_BOC_MSB 5
`define RTCS_CFG_STK_RST 6
`define RTCS_CFG_RESET 8'h00
// Brown-out configuration code that puts brown-out under software control
`define RTCS_BOC_SOFTWARE 2'h1

// Status register bit positions
`define RTCS_ST_BROWN 0
`define RTCS_ST_POR 1
`define RTCS_ST_PWRDN 2
`define RTCS_ST_EXPIRED 3
`define RTCS_ST_RSTINS 4
`define RTCS_ST_UNDER 5
`define RTCS_ST_SWBRN 6
`define RTCS_ST_FULL 7
// Status value after power-on, with software brown-out enable cleared
`define RTCS_STATUS_POR 8'h1C

`endif

// *** verilog/rtcs_pkg.sv ***
// Purpose: Types shared by the reset sequencer files
// Assumes: Constants live in rtcs_defines.svh
// Notes: Enumerations carry no explicit codes
package rtcs_pkg;

  // Oscillator configuration
  typedef enum logic [2:0] {
    low_power_crystal_mode,
    medium_crystal_mode,
    fast_crystal_mode,
    fast_crystal_multiplied_mode,
    external_clock_mode,
    resistor_capacitor_mode,
    internal_osc_mode
  } rtcs_osc_mode_t;

  // Core power mode reported by the clock controller
  typedef enum logic [1:0] {
    pm_full_power,
    pm_run,
    pm_idle,
    pm_sleep
  } rtcs_power_mode_t;

  // Time-out sequencer states
  typedef enum logic [2:0] {
    st_por,
    st_pwrup,
    st_start,
    st_pll,
    st_wait_clear,
    st_run
  } rtcs_seq_state_t;

endpackage

// *** verilog/rtcs_timer.sv ***
// Purpose: Loadable down-counter used for every time-out stage
// Assumes: Load value of at least one
// Notes: Done is a one-cycle pulse on the tick that empties the counter
`timescale 1ns/10ps
module rtcs_timer #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic abort,
  input wire logic tick,
  // Status
  output logic busy,
  output logic done
);

  // Remaining count
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  // Done pulse register
  logic done_reg;
  logic done_next;
  // Counter is one tick from empty
  wire logic last_tick = (cnt_reg == WIDTH'(1)) && tick;

  // Abort wins, then load, then count down on each tick
  assign cnt_next = abort ? '0 :
                    load ? load_value :
                    ((cnt_reg != '0) && tick) ? cnt_reg - WIDTH'(1) : cnt_reg;
  assign done_next = !abort && !load && last_tick;

  // Counter state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;

endmodule // rtcs_timer

// *** verilog/rtcs_reset_seq.sv ***
// Purpose: Power-up time-out sequencer and reset-cause status flags
// Assumes: All inputs synchronous to ref_clk; oscillator ticks arrive as enables
// Notes: Time-outs count from the power-on pulse; master clear only gates release
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "rtcs_defines.svh"

module rtcs_reset_seq #(
  parameter int PWRUP_CYCLES = `RTCS_PWRUP_CYCLES,
  parameter int PLL_CYCLES = `RTCS_PLL_CYCLES,
  parameter int START_PERIODS = `RTCS_START_PERIODS,
  parameter int PC_WIDTH = 21,
  parameter int TIMER_WIDTH = 24
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Reset and wake sources
  input wire logic por_pulse,
  input wire logic master_clear_pin_b,
  input wire logic watchdog_timeout,
  input wire logic reset_instr,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic wake_interrupt,
  input wire logic pm_osc_exit,
  // Core state
  input wire logic [1:0] power_mode,
  input wire logic [PC_WIDTH-1:0] current_pc,
  input wire logic osc_tick,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core control
  output logic core_reset,
  output logic pc_load,
  output logic [PC_WIDTH-1:0] pc_value,
  output logic [7:0] status_flags
);

  // Refuse parameters the counters cannot hold
  if (PWRUP_CYCLES < 1 || PLL_CYCLES < 1 || START_PERIODS < 1 ||
      longint'(PWRUP_CYCLES) >= (longint'(1) << TIMER_WIDTH) ||
      longint'(PLL_CYCLES) >= (longint'(1) << TIMER_WIDTH) ||
      longint'(START_PERIODS) >= (longint'(1) << TIMER_WIDTH) || PC_WIDTH < 2) begin : g_bad
    $error("rtcs_reset_seq: timer width or counts out of range");
  end

  // Sequencer state
  rtcs_pkg::rtcs_seq_state_t state_reg;
  rtcs_pkg::rtcs_seq_state_t state_next;
  // Configuration, status and scratch registers
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [31:0] scratch_reg;
  // Outputs held in flops
  logic core_reset_reg;
  logic pc_load_reg;
  logic [PC_WIDTH-1:0] pc_value_reg;
  logic [PC_WIDTH-1:0] pc_value_next;
  logic pc_load_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Edge detect on the power-on pulse and master clear
  logic por_prev_reg;
  logic clear_prev_reg;
  // Timer control
  logic tmr_load;
  logic [TIMER_WIDTH-1:0] tmr_value;
  logic tmr_busy;
  logic tmr_done;

  // Configuration decode
  wire rtcs_pkg::rtcs_osc_mode_t osc_mode =
    rtcs_pkg::rtcs_osc_mode_t'(cfg_reg[`RTCS_CFG_OSC_MSB:`RTCS_CFG_OSC_LSB]);
  wire logic pwrup_on = !cfg_reg[`RTCS_CFG_PWRUP_DIS];
  wire logic [1:0] brown_out_config = cfg_reg[`RTCS_CFG_BOC_MSB:`RTCS_CFG_BOC_LSB];
  wire logic stack_error_reset_enable = cfg_reg[`RTCS_CFG_STK_RST];
  wire logic sw_brown_mode = (brown_out_config == `RTCS_BOC_SOFTWARE);
  // Modes that use the oscillator start-up count
  wire logic crystal = (osc_mode == rtcs_pkg::low_power_crystal_mode) ||
                       (osc_mode == rtcs_pkg::medium_crystal_mode) ||
                       (osc_mode == rtcs_pkg::fast_crystal_mode) ||
                       (osc_mode == rtcs_pkg::fast_crystal_multiplied_mode);
  wire logic pll_mode = (osc_mode == rtcs_pkg::fast_crystal_multiplied_mode);
  wire rtcs_pkg::rtcs_power_mode_t pmode = rtcs_pkg::rtcs_power_mode_t'(power_mode);
  wire logic low_power = (pmode == rtcs_pkg::pm_idle) || (pmode == rtcs_pkg::pm_sleep);

  // Register port decode
  wire logic sel_cfg = (reg_addr == `RTCS_ADDR_CONFIG);
  wire logic sel_status = (reg_addr == `RTCS_ADDR_STATUS);
  wire logic sel_pc = (reg_addr == `RTCS_ADDR_PC);
  wire logic sel_seq = (reg_addr == `RTCS_ADDR_SEQ);
  wire logic sel_scratch = (reg_addr == `RTCS_ADDR_SCRATCH);
  wire logic wr_status = reg_wr && sel_status;

  // Event qualification: core events count only while running
  wire logic running = (state_reg == rtcs_pkg::st_run);
  wire logic por_rise = por_pulse && !por_prev_reg;
  wire logic clear_fall = running && clear_prev_reg && !master_clear_pin_b;
  wire logic ev_ovf = running && stack_overflow;
  wire logic ev_unf = running && stack_underflow;
  wire logic ev_dog = running && watchdog_timeout;
  wire logic ev_rst_ins = running && reset_instr;
  wire logic ev_int = running && wake_interrupt && low_power;

  // Time-out sequencer: next state and timer loading
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_value = '0;
    case (state_reg)
      rtcs_pkg::st_por: begin
        // Stages start when the power-on pulse ends, master clear ignored
        if (!por_pulse) begin
          if (pwrup_on) begin
            state_next = rtcs_pkg::st_pwrup;
            tmr_load = 1'b1;
            tmr_value = TIMER_WIDTH'(PWRUP_CYCLES);
          end else if (crystal) begin
            state_next = rtcs_pkg::st_start;
            tmr_load = 1'b1;
            tmr_value = TIMER_WIDTH'(START_PERIODS);
          end else begin
            state_next = rtcs_pkg::st_wait_clear;
          end
        end
      end
      rtcs_pkg::st_pwrup: begin
        // Start-up count follows the power-up timer
        if (tmr_done) begin
          if (crystal) begin
            state_next = rtcs_pkg::st_start;
            tmr_load = 1'b1;
            tmr_value = TIMER_WIDTH'(START_PERIODS);
          end else begin
            state_next = rtcs_pkg::st_wait_clear;
          end
        end
      end
      rtcs_pkg::st_start: begin
        // Lock delay only after the start-up count in PLL mode
        if (tmr_done) begin
          if (pll_mode) begin
            state_next = rtcs_pkg::st_pll;
            tmr_load = 1'b1;
            tmr_value = TIMER_WIDTH'(PLL_CYCLES);
          end else begin
            state_next = rtcs_pkg::st_wait_clear;
          end
        end
      end
      rtcs_pkg::st_pll: begin
        // Lock delay done
        if (tmr_done) begin
          state_next = rtcs_pkg::st_wait_clear;
        end
      end
      rtcs_pkg::st_wait_clear: begin
        // Immediate release once master clear goes high
        if (master_clear_pin_b) begin
          state_next = rtcs_pkg::st_run;
        end
      end
      rtcs_pkg::st_run: begin
        // Oscillator restart after leaving a power-managed mode
        if (pm_osc_exit && crystal) begin
          state_next = rtcs_pkg::st_start;
          tmr_load = 1'b1;
          tmr_value = TIMER_WIDTH'(START_PERIODS);
        end
      end
      default: begin
        state_next = rtcs_pkg::st_por;
      end
    endcase
    // Power-on pulse restarts the whole sequence
    if (por_pulse) begin
      state_next = rtcs_pkg::st_por;
    end
  end

  // Status flags, program counter load; hardware set wins over software write
  always_comb begin
    status_next = status_reg;
    pc_load_next = 1'b0;
    pc_value_next = pc_value_reg;
    if (wr_status) begin
      status_next = reg_wdata[7:0];
    end
    if (por_pulse) begin
      status_next = `RTCS_STATUS_POR;
      status_next[`RTCS_ST_SWBRN] = sw_brown_mode;
      pc_value_next = '0;
      pc_load_next = por_rise;
    end else if (clear_fall) begin
      pc_value_next = '0;
      pc_load_next = 1'b1;
      if (low_power) begin
        status_next[`RTCS_ST_EXPIRED] = 1'b1;
        status_next[`RTCS_ST_PWRDN] = 1'b0;
      end else if (pmode == rtcs_pkg::pm_run) begin
        status_next[`RTCS_ST_EXPIRED] = 1'b1;
      end
    end else if (ev_ovf) begin
      status_next[`RTCS_ST_FULL] = 1'b1;
      if (stack_error_reset_enable) begin
        pc_value_next = '0;
        pc_load_next = 1'b1;
      end
    end else if (ev_unf) begin
      status_next[`RTCS_ST_UNDER] = 1'b1;
      if (stack_error_reset_enable) begin
        pc_value_next = '0;
        pc_load_next = 1'b1;
      end
    end else if (ev_dog) begin
      status_next[`RTCS_ST_EXPIRED] = 1'b0;
      pc_load_next = 1'b1;
      if (low_power) begin
        // Wake-up: resume, other registers untouched
        status_next[`RTCS_ST_PWRDN] = 1'b0;
        pc_value_next = current_pc + PC_WIDTH'(`RTCS_PC_STEP);
      end else begin
        pc_value_next = '0;
      end
    end else if (ev_rst_ins) begin
      status_next[`RTCS_ST_RSTINS] = 1'b0;
      pc_value_next = '0;
      pc_load_next = 1'b1;
    end else if (ev_int) begin
      status_next[`RTCS_ST_PWRDN] = 1'b0;
      pc_value_next = current_pc + PC_WIDTH'(`RTCS_PC_STEP);
      pc_load_next = 1'b1;
    end
    // Software brown-out enable reads zero outside software mode
    if (!sw_brown_mode) begin
      status_next[`RTCS_ST_SWBRN] = 1'b0;
    end
  end

  // Configuration write
  assign cfg_next = (reg_wr && sel_cfg) ? reg_wdata[7:0] : cfg_reg;

  // Read mux, data valid only in the cycle after the strobe
  assign rdata_next = !reg_rd ? 32'h0000_0000 :
                      sel_cfg ? {24'h00_0000, cfg_reg} :
                      sel_status ? {24'h00_0000, status_reg} :
                      sel_pc ? 32'(pc_value_reg) :
                      sel_seq ? {27'h000_0000, tmr_busy, 1'b0, state_reg} :
                      sel_scratch ? scratch_reg : 32'h0000_0000;

  // Sequencer, flags and output flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= rtcs_pkg::st_por;
      cfg_reg <= `RTCS_CFG_RESET;
      status_reg <= `RTCS_STATUS_POR;
      por_prev_reg <= 1'b0;
      clear_prev_reg <= 1'b1;
      core_reset_reg <= 1'b1;
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      status_reg <= status_next;
      por_prev_reg <= por_pulse;
      clear_prev_reg <= master_clear_pin_b;
      // Core runs only when sequence done and master clear high
      core_reset_reg <= !((state_next == rtcs_pkg::st_run) && master_clear_pin_b);
      pc_load_reg <= pc_load_next;
      pc_value_reg <= pc_value_next;
      rdata_reg <= rdata_next;
    end
  end

  // Unaffected register: no reset, kept through every reset event
  always_ff @(posedge ref_clk) begin
    if (reg_wr && sel_scratch) begin
      scratch_reg <= reg_wdata;
    end
  end

  // Shared stage timer; start-up stage counts oscillator periods
  rtcs_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_value(tmr_value),
    .abort(por_pulse),
    .tick((state_reg == rtcs_pkg::st_start) ? osc_tick : 1'b1),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  assign reg_rdata = rdata_reg;
  assign core_reset = core_reset_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign status_flags = status_reg;

endmodule // rtcs_reset_seq

// *** testbench/rtcs_reset_seq_checker.sv ***
// Purpose: Port-level assertions for the reset sequencer
// Assumes: Single ref_clk domain, rst_b async active low
// Notes: Clear, watchdog, interrupt and stack events are judged only while the core runs; power-on is judged at any time
`timescale 1ns/10ps
module rtcs_reset_seq_checker #(
  parameter int PC_WIDTH = 21
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Sources
  input wire logic por_pulse,
  input wire logic master_clear_pin_b,
  input wire logic watchdog_timeout,
  input wire logic reset_instr,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic wake_interrupt,
  input wire logic [1:0] power_mode,
  input wire logic [PC_WIDTH-1:0] current_pc,
  // Core control
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [PC_WIDTH-1:0] pc_value,
  input wire logic [7:0] status_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Core out of reset and no power-on
  sequence s_live;
    !core_reset && !por_pulse;
  endsequence
  // Running with no higher-priority source
  sequence s_run_ok;
    s_live ##0 (master_clear_pin_b && !stack_overflow && !stack_underflow);
  endsequence
  property p_por_load;
    $rose(por_pulse) |-> ##[1:2] (pc_load && pc_value == '0);
  endproperty
  a_por_load: assert property (p_por_load) else $error("no pc load after power-on");
  property p_por_flags;
    por_pulse |=> (status_flags & 8'hBF) == 8'h1C;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("bad flags after power-on");
  property p_clear_hold;
    !master_clear_pin_b && $past(!master_clear_pin_b) |-> core_reset;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("core runs with clear low");
  property p_release;
    $fell(core_reset) |-> $past(master_clear_pin_b) && !$past(por_pulse);
  endproperty
  a_release: assert property (p_release) else $error("release while held");
  property p_clear_full;
    s_live ##0 ($fell(master_clear_pin_b) && power_mode == 2'h0)
      |=> pc_load && pc_value == '0 && $stable(status_flags);
  endproperty
  a_clear_full: assert property (p_clear_full) else $error("clear at full power");
  property p_clear_sleep;
    s_live ##0 ($fell(master_clear_pin_b) && power_mode[1])
      |=> pc_load && status_flags[3] && !status_flags[2];
  endproperty
  a_clear_sleep: assert property (p_clear_sleep) else $error("clear in sleep");
  property p_dog_run;
    s_run_ok ##0 (watchdog_timeout && !power_mode[1])
      |=> pc_load && pc_value == '0 && !status_flags[3];
  endproperty
  a_dog_run: assert property (p_dog_run) else $error("watchdog in run");
  property p_dog_sleep;
    s_run_ok ##0 (watchdog_timeout && power_mode[1])
      |=> pc_load && pc_value == PC_WIDTH'($past(current_pc) + 2)
        && status_flags[3:2] == 2'h0 && !core_reset;
  endproperty
  a_dog_sleep: assert property (p_dog_sleep) else $error("watchdog wake");
  property p_int_wake;
    s_run_ok ##0 (wake_interrupt && power_mode[1] && !watchdog_timeout && !reset_instr)
      |=> pc_value == PC_WIDTH'($past(current_pc) + 2) && !status_flags[2];
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interrupt wake");
  property p_overflow;
    s_live ##0 (master_clear_pin_b && stack_overflow) |=> status_flags[7];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag");
  property p_underflow;
    s_live ##0 (master_clear_pin_b && !stack_overflow && stack_underflow)
      |=> status_flags[5] && !core_reset;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow flag");
endmodule // rtcs_reset_seq_checker

bind rtcs_reset_seq rtcs_reset_seq_checker #(.PC_WIDTH(PC_WIDTH)) u_rtcs_reset_seq_checker (
  .ref_clk, .rst_b, .por_pulse, .master_clear_pin_b, .watchdog_timeout, .reset_instr,
  .stack_overflow, .stack_underflow, .wake_interrupt, .power_mode, .current_pc,
  .core_reset, .pc_load, .pc_value, .status_flags
);

// *** testbench/rtcs_reset_seq_tb_top.sv ***
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Shortened stage counts, osc tick every second cycle
// Notes: Release windows allow a few transition cycles
`timescale 1ns/10ps
module rtcs_reset_seq_tb_top;
  // Stimulus
  logic ref_clk = 1'b0, rst_b = 1'b0, por_pulse = 1'b0, master_clear_pin_b = 1'b1;
  logic watchdog_timeout = 1'b0, reset_instr = 1'b0, stack_overflow = 1'b0;
  logic stack_underflow = 1'b0, wake_interrupt = 1'b0, osc_tick = 1'b0, pm_osc_exit = 1'b0;
  logic [1:0] power_mode = 2'h0;
  logic [20:0] current_pc = 21'h001234;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  // Observed
  logic [31:0] reg_rdata, rd;
  logic core_reset, pc_load;
  logic [20:0] pc_value;
  logic [7:0] status_flags;
  int num_errors = 0, compares = 0;
  // Device under test with short stages
  rtcs_reset_seq #(.PWRUP_CYCLES(20), .PLL_CYCLES(10), .START_PERIODS(8)) u_rtcs_reset_seq (
    .ref_clk, .rst_b, .por_pulse, .master_clear_pin_b, .watchdog_timeout, .reset_instr,
    .stack_overflow, .stack_underflow, .wake_interrupt, .pm_osc_exit, .power_mode,
    .current_pc, .osc_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_reset, .pc_load, .pc_value, .status_flags
  );
  // Clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Oscillator period: one high cycle in two
  always @(posedge ref_clk) begin
    osc_tick <= ~osc_tick;
  end
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Register read, data taken in the following cycle
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Count edges until the core is released
  task automatic wait_run(output int n);
    n = 0;
    while (core_reset !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  // First start after reset: timer plus start-up count
  task automatic t_start;
    int n;
    wait_run(n);
    chk("start_min", n >= 35, 1'b1);
    chk("start_max", n <= 47, 1'b1);
    rdr(8'h04);
    chk("status_rst", rd, 32'h1C);
    rdr(8'h00);
    chk("config_rst", rd, 32'h0);
    rdr(8'h0C);
    chk("seq_run", rd, 32'h5);
    wr(8'h20, 32'hFF);
    rdr(8'h20);
    chk("unmapped", rd, 32'h0);
    wr(8'h10, 32'h5A);
  endtask
  // Power-on sequence for one configuration
  task automatic t_seq(input logic [7:0] cfg, input int lo);
    int n;
    wr(8'h00, {24'h0, cfg});
    @(posedge ref_clk);
    por_pulse <= 1'b1;
    repeat (2) @(posedge ref_clk);
    por_pulse <= 1'b0;
    #1 chk("held", core_reset, 1'b1);
    wait_run(n);
    chk("rel_min", n >= lo, 1'b1);
    chk("rel_max", n <= lo + 12, 1'b1);
    rdr(8'h04);
    chk("status_por", rd, (cfg[5:4] == 2'h1) ? 32'h5C : 32'h1C);
    rdr(8'h10);
    chk("scratch", rd, 32'h5A);
  endtask
  // Exit from a power-managed mode: start-up count (and lock), no power-up timer
  task automatic t_exit(input logic [7:0] cfg, input int lo);
    int n;
    wr(8'h00, {24'h0, cfg});
    @(posedge ref_clk);
    pm_osc_exit <= 1'b1;
    @(posedge ref_clk);
    pm_osc_exit <= 1'b0;
    #1 chk("exit_held", core_reset, 1'b1);
    wait_run(n);
    chk("exit_min", n >= lo, 1'b1);
    chk("exit_max", n <= lo + 12, 1'b1);
  endtask
  // Clear held low past all time-outs
  task automatic t_hold;
    int n;
    wr(8'h00, 32'h04);
    @(posedge ref_clk);
    master_clear_pin_b <= 1'b0;
    por_pulse <= 1'b1;
    repeat (2) @(posedge ref_clk);
    por_pulse <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1 chk("clear_held", core_reset, 1'b1);
    @(posedge ref_clk);
    master_clear_pin_b <= 1'b1;
    wait_run(n);
    chk("clear_prompt", n <= 3, 1'b1);
  endtask
  // One reset or wake event from a known status
  task automatic t_ev(input int kind, input logic [1:0] pm, input logic [7:0] st,
                      input logic [20:0] pc, input bit do_pc);
    int n;
    wr(8'h04, 32'h1C);
    @(posedge ref_clk);
    power_mode <= pm;
    @(posedge ref_clk);
    case (kind)
      0: master_clear_pin_b <= 1'b0;
      1: watchdog_timeout <= 1'b1;
      2: wake_interrupt <= 1'b1;
      3: stack_overflow <= 1'b1;
      4: stack_underflow <= 1'b1;
      default: reset_instr <= 1'b1;
    endcase
    @(posedge ref_clk);
    {watchdog_timeout, wake_interrupt, stack_overflow, stack_underflow, reset_instr} <= 5'h0;
    repeat (2) @(posedge ref_clk);
    master_clear_pin_b <= 1'b1;
    wait_run(n);
    chk("core_run", core_reset, 1'b0);
    rdr(8'h04);
    chk("status_ev", rd, {24'h0, st});
    if (do_pc) begin
      chk("pc_ev", {11'h0, pc_value}, {11'h0, pc});
      rdr(8'h08);
      chk("pc_reg", rd, {11'h0, pc});
    end
  endtask
  // Verdict
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_start();
    t_seq(8'h00, 35);
    t_seq(8'h03, 45);
    t_seq(8'h0B, 25);
    t_seq(8'h0A, 15);
    t_seq(8'h14, 20);
    t_seq(8'h0D, 0);
    t_seq(8'h0E, 0);
    t_exit(8'h03, 25);
    t_exit(8'h02, 15);
    t_hold();
    t_ev(0, 2'h0, 8'h1C, 21'h0, 1'b1);
    t_ev(0, 2'h3, 8'h18, 21'h0, 1'b1);
    t_ev(1, 2'h1, 8'h14, 21'h0, 1'b1);
    t_ev(2, 2'h2, 8'h18, 21'h001236, 1'b1);
    t_ev(5, 2'h0, 8'h0C, 21'h0, 1'b1);
    t_ev(1, 2'h3, 8'h10, 21'h001236, 1'b1);
    t_ev(4, 2'h0, 8'h3C, 21'h001236, 1'b1);
    wr(8'h00, 32'h40);
    t_ev(3, 2'h0, 8'h9C, 21'h0, 1'b1);
    wrap_up();
  end
  // Hang guard
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
endmodule // rtcs_reset_seq_tb_top
